// >>> hw/bus_cycle_params.svh
// Constants for the processor bus-cycle and clock-stop blocks.
// Assumes inclusion by both ends and the interface; definitions only.
`ifndef BUS_CYCLE_PARAMS_SVH
`define BUS_CYCLE_PARAMS_SVH
`define ADDR_W 32
`define DATA_W 32
`define BURST_WORDS 4
`define BURST_CNT_W 2
`define LINE_OFFSET_MASK 32'h0000000F
`define STOP_GRANT_ADDR 32'h00000010
`define STOP_GRANT_BE 4'hB
`define STOP_REARM_CLOCKS 5
`define STOP_REARM_W 3
`define BUF_DEPTH 2
`endif

// >>> hw/bus_cycle_pkg.sv
// Types used by the processor end of the bus and by the testbench.
// Assumes the params header is compiled alongside.
package bus_cycle_pkg;
   typedef enum logic [2:0] {
      CYC_IDLE = 3'h0,
      CYC_BURST_WB = 3'h1,
      CYC_MEM_RD = 3'h2,
      CYC_MEM_WR = 3'h3,
      CYC_LOCK_RD = 3'h4,
      CYC_LOCK_WR = 3'h5,
      CYC_STOP_GRANT = 3'h6,
      CYC_IO = 3'h7
   } cyc_kind_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h3,
      ST_DONE = 3'h2,
      ST_ABORT = 3'h6,
      ST_GRANT = 3'h7,
      ST_HOLD = 3'h5
   } bus_state_t;
endpackage

// >>> hw/cpu_bus_if.sv
// Bus between the processor end and the system end.
// Assumes one clock; the testbench resolves tristates from enables.
`timescale 1ns/1ns
`include "bus_cycle_params.svh"
interface cpu_bus_if;
   logic address_strobe_n;
   logic [`ADDR_W-1:0] addr;
   logic [3:0] byte_lane_enables_n;
   logic mem_not_io;
   logic data_not_code;
   logic write_not_read;
   logic burst_last_n;
   logic cache_n;
   logic cache_oe;
   logic lock_n;
   logic multi_cycle_indicator_n;
   logic [`DATA_W-1:0] data_out;
   logic data_oe;
   logic [`DATA_W-1:0] data_in;
   logic ready_n;
   logic burst_ready_n;
   logic line_fill_permit_n;
   logic bus_abort_request_n;
   logic address_float_request;
   logic hold_req;
   logic hold_grant_ack;
   logic clock_stop_request_n;
   modport cpu (output address_strobe_n, addr, byte_lane_enables_n, mem_not_io, data_not_code,
      write_not_read, burst_last_n, cache_n, cache_oe, lock_n, multi_cycle_indicator_n,
      data_out, data_oe, hold_grant_ack,
      input data_in, ready_n, burst_ready_n, line_fill_permit_n, bus_abort_request_n,
      address_float_request, hold_req, clock_stop_request_n);
   modport sys (input address_strobe_n, addr, byte_lane_enables_n, mem_not_io, data_not_code,
      write_not_read, burst_last_n, cache_n, cache_oe, lock_n, multi_cycle_indicator_n,
      data_out, data_oe, hold_grant_ack,
      output data_in, ready_n, burst_ready_n, line_fill_permit_n, bus_abort_request_n,
      address_float_request, hold_req, clock_stop_request_n);
endinterface

// >>> hw/sys_bus_end.sv
// System-side end: answers cycles, drives clock-stop request and hold.
// Assumes the processor end on the same clock through cpu_bus_if.
`timescale 1ns/1ns
`include "bus_cycle_params.svh"
module sys_bus_end (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   cpu_bus_if.sys bus,
   input wire logic use_burst,
   input wire logic fill_permit,
   input wire logic abort_req,
   input wire logic float_req,
   input wire logic hold_in,
   input wire logic stop_want,
   input wire logic [`DATA_W-1:0] rd_data,
   output logic [`DATA_W-1:0] wr_data,
   output logic wr_valid,
   output logic stop_granted
);
   logic busy;
   logic is_grant;
   logic stop_n;
   logic [`STOP_REARM_W-1:0] rearm;
   logic answer;
   assign answer = busy && ce;
   assign bus.ready_n = !(answer && !use_burst);
   assign bus.burst_ready_n = !(answer && use_burst);
   assign bus.line_fill_permit_n = !fill_permit;
   assign bus.bus_abort_request_n = !abort_req;
   assign bus.address_float_request = float_req;
   assign bus.hold_req = hold_in;
   assign bus.data_in = rd_data;
   assign bus.clock_stop_request_n = stop_n;
   // Cycle tracking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         is_grant <= 1'b0;
      end else if (ce) begin
         if (!bus.address_strobe_n) begin
            busy <= 1'b1;
            is_grant <= !bus.mem_not_io && bus.write_not_read &&
               bus.addr == `STOP_GRANT_ADDR && bus.byte_lane_enables_n == `STOP_GRANT_BE;
         end else if (answer && (bus.burst_last_n == 1'b0 || !use_burst)) begin
            busy <= 1'b0;
         end
      end
   end
   // Write data capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_data <= 32'h00000000;
         wr_valid <= 1'b0;
      end else if (ce) begin
         wr_valid <= answer && bus.write_not_read && bus.mem_not_io;
         wr_data <= bus.data_out;
      end
   end
   // Clock-stop request: held until stop-grant acknowledged, then re-arm gap
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_n <= 1'b1;
         stop_granted <= 1'b0;
         rearm <= 3'h0;
      end else if (ce) begin
         if (answer && is_grant) begin
            stop_granted <= 1'b1;
         end
         if (rearm != 3'h0) begin
            rearm <= rearm - 3'h1;
         end
         if (stop_n) begin
            if (stop_want && rearm == 3'h0 && !stop_granted) begin
               stop_n <= 1'b0;
            end
         end else if (stop_granted && !stop_want) begin
            stop_n <= 1'b1;
            stop_granted <= 1'b0;
            rearm <= 3'(`STOP_REARM_CLOCKS);
         end
      end
   end
endmodule

// >>> hw/cpu_bus_end.sv
// Processor-side end: bus cycles, burst write-back, locked sequences, clock stop.
// Assumes the system end answers with ready or burst-ready on the same clock.
`timescale 1ns/1ns
`include "bus_cycle_params.svh"
// Notes on behaviour
// - Write-back bursts: four words from offset zero
// - Cache flag asserted for cacheable reads, write-backs
// - Cache flag negated for other cycle kinds
// - Cache flag driven only in write-back mode
// - Cache flag valid from strobe to ready
// - Cache flag floats after abort or hold
// - Burst starts with cache low, returns high
// - Burst-last high mid-burst, low at end
// - Ready instead of burst-ready ends burst
// - Locked accesses always go to the bus
// - Hold ignored during locked; abort honoured
// - Locked hit clean: invalidate, read externally
// - Locked hit dirty: copy back, invalidate, read
// - Drain before lock; nothing until final ready (a clean locked read needs only buffer room; only hold is held off mid-lock)
// - Multi-cycle indicator only in write-through mode
// - Clock stop: drain, issue stop-grant, stop clock
// - No clock stop while hold acknowledged
// - Request release resumes, no acknowledge cycles
// - Request priority order depends on cache mode
// - System holds request until grant acknowledged
// - Five clocks negated before next request
// - Stop-grant cycle encoding, must be acknowledged
module cpu_bus_end #(
   parameter int BUF_DEPTH = `BUF_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   cpu_bus_if.cpu bus,
   input wire logic write_back_mode,
   input wire logic req_valid,
   output logic req_ready,
   input wire bus_cycle_pkg::cyc_kind_t req_kind,
   input wire logic [`ADDR_W-1:0] req_addr,
   input wire logic [`DATA_W-1:0] req_data,
   input wire logic req_cacheable,
   input wire logic req_snoop_wb,
   input wire logic req_hit,
   input wire logic req_dirty,
   input wire logic req_lock_last,
   input wire logic flush_busy,
   input wire logic [5:0] ext_req,
   output logic [2:0] ext_grant,
   output logic invalidate_line,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [`DATA_W-1:0] rd_data,
   output logic clock_stopped,
   output logic resume_pulse
);
   bus_cycle_pkg::bus_state_t state;
   bus_cycle_pkg::cyc_kind_t kind;
   logic [`BURST_CNT_W-1:0] beat;
   logic [`ADDR_W-1:0] base;
   logic [`DATA_W-1:0] wdata;
   logic cacheable;
   logic in_lock;
   logic wb_first;
   logic stop_pending;
   logic stop_seen;
   logic hold_ack;
   logic [`DATA_W-1:0] buf_data [BUF_DEPTH];
   logic [1:0] buf_cnt;
   logic buf_wp;
   logic buf_rp;
   logic done_beat;
   logic last_beat;
   logic bursting;
   logic aborted;
   logic idle;
   assign idle = state == bus_cycle_pkg::ST_IDLE;
   assign aborted = !bus.bus_abort_request_n;
   assign done_beat = state == bus_cycle_pkg::ST_DATA && (!bus.ready_n || !bus.burst_ready_n) && !aborted;
   assign bursting = kind == bus_cycle_pkg::CYC_BURST_WB && bus.ready_n;
   assign last_beat = done_beat && (kind != bus_cycle_pkg::CYC_BURST_WB || beat == 2'(`BURST_WORDS - 1));
   // Request accepted only when idle, no stop pending and buffer room
   assign req_ready = ce && idle && !hold_ack && !stop_pending && !clock_stopped && buf_cnt != 2'(BUF_DEPTH) &&
      !(req_hit && req_dirty && req_kind == bus_cycle_pkg::CYC_LOCK_RD && !wb_first);
   // Priority: 0 reset,1 flush,2 soft reset,3 mgmt,4 nmi,5 maskable; 2 before 1 in write-through; clock stop last
   function automatic logic [2:0] pick(input logic [5:0] r, input logic wb);
      logic [5:0] o;
      o = wb ? r : {r[5:3], r[1], r[2], r[0]};
      pick = 3'h7;
      for (int i = 5; i >= 0; i--) begin
         if (o[i]) begin
            pick = 3'(i);
         end
      end
      if (!wb && o[1] && !o[0]) begin
         pick = 3'h2;
      end else if (!wb && o[2] && !o[0] && !o[1]) begin
         pick = 3'h1;
      end
   endfunction
   assign ext_grant = pick(ext_req, write_back_mode);
   assign bus.data_oe = state == bus_cycle_pkg::ST_DATA && bus.write_not_read && !hold_ack;
   assign bus.cache_oe = write_back_mode && !hold_ack && !aborted;
   assign bus.hold_grant_ack = hold_ack;
   // Bus cycle sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= bus_cycle_pkg::ST_IDLE;
         kind <= bus_cycle_pkg::CYC_IDLE;
         beat <= 2'h0;
         base <= 32'h00000000;
         wdata <= 32'h00000000;
         cacheable <= 1'b0;
         wb_first <= 1'b0;
         invalidate_line <= 1'b0;
      end else if (ce) begin
         invalidate_line <= 1'b0;
         case (state)
            bus_cycle_pkg::ST_IDLE: begin
               if (stop_pending && !hold_ack && !flush_busy && buf_cnt == 2'h0) begin
                  kind <= bus_cycle_pkg::CYC_STOP_GRANT;
                  base <= `STOP_GRANT_ADDR;
                  cacheable <= 1'b0;
                  state <= bus_cycle_pkg::ST_ADDR;
               end else if (req_valid && req_ready) begin
                  kind <= req_kind;
                  // Write-back bursts start on the line boundary
                  base <= req_kind == bus_cycle_pkg::CYC_BURST_WB ? req_addr & ~`LINE_OFFSET_MASK : req_addr;
                  wdata <= req_data;
                  cacheable <= req_kind == bus_cycle_pkg::CYC_BURST_WB ||
                     (req_kind == bus_cycle_pkg::CYC_MEM_RD && req_cacheable) ||
                     (req_snoop_wb && req_kind == bus_cycle_pkg::CYC_BURST_WB);
                  invalidate_line <= req_kind == bus_cycle_pkg::CYC_LOCK_RD && req_hit;
                  wb_first <= 1'b0;
                  state <= bus_cycle_pkg::ST_ADDR;
               end else if (req_valid && req_kind == bus_cycle_pkg::CYC_LOCK_RD && req_hit && req_dirty &&
                  !stop_pending && !hold_ack && buf_cnt == 2'h0) begin
                  kind <= bus_cycle_pkg::CYC_BURST_WB;
                  base <= req_addr & ~`LINE_OFFSET_MASK;
                  cacheable <= 1'b1;
                  wb_first <= 1'b1;
                  state <= bus_cycle_pkg::ST_ADDR;
               end
               beat <= 2'h0;
            end
            bus_cycle_pkg::ST_ADDR: begin
               state <= aborted ? bus_cycle_pkg::ST_ABORT : bus_cycle_pkg::ST_DATA;
            end
            bus_cycle_pkg::ST_DATA: begin
               if (aborted) begin
                  state <= bus_cycle_pkg::ST_ABORT;
               end else if (last_beat) begin
                  state <= bus_cycle_pkg::ST_IDLE;
                  cacheable <= 1'b0;
               end else if (done_beat && bursting) begin
                  beat <= beat + 2'h1;
                  cacheable <= 1'b1;
               end else if (done_beat) begin
                  state <= bus_cycle_pkg::ST_ADDR;
                  beat <= beat + 2'h1;
               end
            end
            bus_cycle_pkg::ST_ABORT: begin
               if (!aborted) begin
                  state <= bus_cycle_pkg::ST_ADDR;
               end
            end
            default: begin
               state <= bus_cycle_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // Hold acknowledge: not granted mid-lock or mid-cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_ack <= 1'b0;
      end else if (ce) begin
         hold_ack <= bus.hold_req && idle && !in_lock && !(req_valid && req_ready);
      end
   end
   // Lock span: open at first locked cycle, closed after final answer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_lock <= 1'b0;
      end else if (ce) begin
         if (idle && req_valid && req_ready &&
            (req_kind == bus_cycle_pkg::CYC_LOCK_RD || req_kind == bus_cycle_pkg::CYC_LOCK_WR)) begin
            in_lock <= 1'b1;
         end else if (last_beat && kind == bus_cycle_pkg::CYC_LOCK_WR && req_lock_last) begin
            in_lock <= 1'b0;
         end
      end
   end
   // Clock stop: recognised, granted, then released on request rising
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_pending <= 1'b0;
         stop_seen <= 1'b1;
         clock_stopped <= 1'b0;
         resume_pulse <= 1'b0;
      end else if (ce) begin
         resume_pulse <= 1'b0;
         if (!bus.clock_stop_request_n && !clock_stopped && !hold_ack && ext_grant == 3'h7) begin
            stop_pending <= 1'b1;
         end
         if (last_beat && kind == bus_cycle_pkg::CYC_STOP_GRANT) begin
            stop_pending <= 1'b0;
            clock_stopped <= 1'b1;
         end
         stop_seen <= bus.clock_stop_request_n;
         if (clock_stopped && bus.clock_stop_request_n && !stop_seen) begin
            clock_stopped <= 1'b0;
            resume_pulse <= 1'b1;
         end
      end
   end
   // Two-entry read buffer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         buf_cnt <= 2'h0;
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_data[i] <= 32'h00000000;
         end
      end else if (ce) begin
         if (done_beat && !bus.write_not_read && kind != bus_cycle_pkg::CYC_STOP_GRANT) begin
            buf_data[buf_wp] <= bus.data_in;
            buf_wp <= !buf_wp;
         end
         if (rd_valid && rd_ready) begin
            buf_rp <= !buf_rp;
         end
         buf_cnt <= buf_cnt + 2'(done_beat && !bus.write_not_read && kind != bus_cycle_pkg::CYC_STOP_GRANT)
            - 2'(rd_valid && rd_ready);
      end
   end
   assign rd_valid = buf_cnt != 2'h0;
   assign rd_data = buf_data[buf_rp];
   // Bus pin drive
   always_comb begin
      bus.address_strobe_n = !(state == bus_cycle_pkg::ST_ADDR && !aborted);
      bus.addr = base | {26'h0, beat, 4'h0} >> 2;
      bus.byte_lane_enables_n = kind == bus_cycle_pkg::CYC_STOP_GRANT ? `STOP_GRANT_BE : 4'h0;
      bus.mem_not_io = kind != bus_cycle_pkg::CYC_STOP_GRANT && kind != bus_cycle_pkg::CYC_IO;
      bus.data_not_code = kind != bus_cycle_pkg::CYC_STOP_GRANT;
      bus.write_not_read = kind == bus_cycle_pkg::CYC_BURST_WB || kind == bus_cycle_pkg::CYC_MEM_WR ||
         kind == bus_cycle_pkg::CYC_LOCK_WR || kind == bus_cycle_pkg::CYC_STOP_GRANT;
      bus.burst_last_n = kind == bus_cycle_pkg::CYC_BURST_WB && beat != 2'(`BURST_WORDS - 1);
      bus.cache_n = !(cacheable && !idle && !(state == bus_cycle_pkg::ST_ADDR &&
         kind == bus_cycle_pkg::CYC_BURST_WB && beat != 2'h0)) || beat != 2'h0;
      bus.lock_n = !in_lock;
      bus.multi_cycle_indicator_n = write_back_mode || !(kind == bus_cycle_pkg::CYC_BURST_WB && !idle);
      bus.data_out = wdata;
   end
endmodule

// >>> dv/cpu_bus_sva.sv
// Checker on the bus that joins the processor end and the system end.
// Assumes the testbench ties each input to the matching interface signal.
`timescale 1ns/1ns
`include "bus_cycle_params.svh"
module cpu_bus_sva (
   input wire logic clk,
   input wire logic nrst,
   input wire logic address_strobe_n,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [3:0] byte_lane_enables_n,
   input wire logic mem_not_io,
   input wire logic data_not_code,
   input wire logic write_not_read,
   input wire logic burst_last_n,
   input wire logic cache_n,
   input wire logic cache_oe,
   input wire logic lock_n,
   input wire logic ready_n,
   input wire logic burst_ready_n,
   input wire logic bus_abort_request_n,
   input wire logic hold_req,
   input wire logic hold_grant_ack,
   input wire logic clock_stop_request_n
);
   logic burst_go, answered, in_burst, grant_open, grant_done;
   logic [1:0] beat;
   logic [2:0] since;
   assign burst_go = !address_strobe_n && mem_not_io && write_not_read && cache_oe && !cache_n && addr[3:0] == 4'h0;
   assign answered = !ready_n || !burst_ready_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence burst_start;
      burst_go;
   endsequence
   sequence ready_revert;
      in_burst && !ready_n && burst_last_n;
   endsequence
   sequence grant_strobe;
      !address_strobe_n && !mem_not_io && addr == `STOP_GRANT_ADDR;
   endsequence
   // Tracks an open burst write-back and its beats
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_burst <= 1'h0;
         beat <= 2'h0;
      end else if (burst_go) begin
         in_burst <= 1'h1;
         beat <= 2'h0;
      end else if (in_burst && (!ready_n || !bus_abort_request_n || (!burst_ready_n && !burst_last_n))) begin
         in_burst <= 1'h0;
      end else if (in_burst && !burst_ready_n) begin
         beat <= beat + 2'h1;
      end
   end
   // Tracks the stop-grant answer and clocks since it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         grant_open <= 1'h0;
         grant_done <= 1'h0;
         since <= 3'h7;
      end else if (grant_open && answered) begin
         grant_open <= 1'h0;
         grant_done <= 1'h1;
         since <= 3'h1;
      end else begin
         if (!address_strobe_n && !mem_not_io && addr == `STOP_GRANT_ADDR) grant_open <= 1'h1;
         if (clock_stop_request_n) grant_done <= 1'h0;
         if (since != 3'h7) since <= since + 3'h1;
      end
   end
   a_burst_second_last: assert property (burst_start |=> burst_last_n)
      else $error("burst-last low in second clock");
   a_burst_four_beats: assert property (in_burst && !burst_ready_n && !burst_last_n |-> beat == 2'h3)
      else $error("burst ended before four words");
   a_burst_cache_high: assert property (in_burst && beat != 2'h0 && cache_oe |-> cache_n)
      else $error("cache flag low after first burst-ready");
   a_cache_neg_kinds: assert property (!address_strobe_n && cache_oe && (!mem_not_io || (!lock_n && !write_not_read)) |-> cache_n)
      else $error("cache flag asserted on io or locked read");
   a_abort_float: assert property ($fell(bus_abort_request_n) |=> !cache_oe)
      else $error("cache flag driven after abort");
   a_lock_no_hold: assert property (!lock_n && hold_req |-> !hold_grant_ack)
      else $error("hold acknowledged inside lock");
   a_grant_encoding: assert property (grant_strobe |-> !data_not_code && write_not_read && byte_lane_enables_n == `STOP_GRANT_BE)
      else $error("stop-grant cycle encoding wrong");
   a_stop_held: assert property ($rose(clock_stop_request_n) |-> grant_done)
      else $error("stop request released before grant answered");
   a_stop_rearm: assert property ($fell(clock_stop_request_n) |-> since > `STOP_REARM_CLOCKS)
      else $error("stop request reasserted too soon");
   a_ready_revert: assert property (ready_revert |-> ##[1:6] !address_strobe_n)
      else $error("no single cycle after ready in burst");
endmodule

// >>> dv/test_cpu_bus_cycle_and_clock_stop.sv
// Self-checking bench for the processor and system ends joined by one bus.
// Assumes the params header, package, interface and both ends are compiled first.
`timescale 1ns/1ns
`include "bus_cycle_params.svh"
module test_cpu_bus_cycle_and_clock_stop;
   logic clk = 1'h0, nrst = 1'h0, wb_mode = 1'h1, req_valid = 1'h0, cacheable = 1'h0, hit = 1'h0, dirty = 1'h0;
   logic lock_last = 1'h0, use_burst = 1'h1, fill = 1'h1, abort_req = 1'h0, hold_in = 1'h0, stop_want = 1'h0;
   logic rd_ready = 1'h1, req_ready, invalidate_line, rd_valid, clock_stopped, resume_pulse, wr_valid, stop_granted;
   logic last_cache_n, last_cache_oe;
   logic [5:0] ext_req = 6'h00;
   logic [2:0] ext_grant;
   logic [`DATA_W-1:0] addr = 32'h0, wdata = 32'h0, sys_rd = 32'h0, cpu_rd, wr_data, last_addr, last_wr;
   bus_cycle_pkg::cyc_kind_t kind = bus_cycle_pkg::CYC_IDLE;
   int strobes = 0, beats = 0, invals = 0, resumes = 0, cycles = 0, failures = 0, samples_checked = 0;
   cpu_bus_if bus();
   cpu_bus_end u_cpu_bus_end (.clk(clk), .nrst(nrst), .ce(1'h1), .bus(bus), .write_back_mode(wb_mode),
      .req_valid(req_valid), .req_ready(req_ready), .req_kind(kind), .req_addr(addr), .req_data(wdata),
      .req_cacheable(cacheable), .req_snoop_wb(1'h0), .req_hit(hit), .req_dirty(dirty), .req_lock_last(lock_last),
      .flush_busy(1'h0), .ext_req(ext_req), .ext_grant(ext_grant), .invalidate_line(invalidate_line),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(cpu_rd), .clock_stopped(clock_stopped),
      .resume_pulse(resume_pulse));
   sys_bus_end u_sys_bus_end (.clk(clk), .nrst(nrst), .ce(1'h1), .bus(bus), .use_burst(use_burst),
      .fill_permit(fill), .abort_req(abort_req), .float_req(1'h0), .hold_in(hold_in), .stop_want(stop_want),
      .rd_data(sys_rd), .wr_data(wr_data), .wr_valid(wr_valid), .stop_granted(stop_granted));
   cpu_bus_sva u_cpu_bus_sva (.clk(clk), .nrst(nrst), .address_strobe_n(bus.address_strobe_n), .addr(bus.addr),
      .byte_lane_enables_n(bus.byte_lane_enables_n), .mem_not_io(bus.mem_not_io), .data_not_code(bus.data_not_code),
      .write_not_read(bus.write_not_read), .burst_last_n(bus.burst_last_n), .cache_n(bus.cache_n),
      .cache_oe(bus.cache_oe), .lock_n(bus.lock_n), .ready_n(bus.ready_n), .burst_ready_n(bus.burst_ready_n),
      .bus_abort_request_n(bus.bus_abort_request_n), .hold_req(bus.hold_req), .hold_grant_ack(bus.hold_grant_ack),
      .clock_stop_request_n(bus.clock_stop_request_n));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (failures == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Holds the request until an edge sees it taken
   task automatic issue(input bus_cycle_pkg::cyc_kind_t k, input logic [31:0] a, input logic c);
      @(posedge clk);
      #1 kind = k;
      addr = a;
      cacheable = c;
      req_valid = 1'h1;
      @(negedge clk);
      while (req_ready !== 1'h1) @(negedge clk);
      @(posedge clk);
      #1 req_valid = 1'h0;
   endtask
   task automatic wait_stopped(input logic want);
      for (int n = 0; n < 300 && clock_stopped !== want; n++) settle(1);
   endtask
   // Bus monitor and hang guard
   always @(posedge clk) begin
      cycles++;
      if (bus.address_strobe_n === 1'h0) begin
         strobes++;
         last_addr = bus.addr;
         last_cache_n = bus.cache_n;
         last_cache_oe = bus.cache_oe;
      end
      if (wr_valid === 1'h1) begin
         beats++;
         last_wr = wr_data;
      end
      invals += int'(invalidate_line === 1'h1);
      resumes += int'(resume_pulse === 1'h1);
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   task automatic t_cache;
      issue(bus_cycle_pkg::CYC_MEM_RD, 32'h00003000, 1'h1);
      settle(8);
      check("cache_rd", last_cache_n, 1'h0);
      check("multi_wb", bus.multi_cycle_indicator_n, 1'h1);
      issue(bus_cycle_pkg::CYC_IO, 32'h00000080, 1'h1);
      settle(8);
      check("cache_io", last_cache_n, 1'h1);
      wdata = 32'h5A5A1234;
      issue(bus_cycle_pkg::CYC_MEM_WR, 32'h00003010, 1'h0);
      settle(8);
      check("wr_data", last_wr, 32'h5A5A1234);
      wb_mode = 1'h0;
      issue(bus_cycle_pkg::CYC_MEM_RD, 32'h00003020, 1'h1);
      settle(8);
      check("cache_float", last_cache_oe, 1'h0);
      wb_mode = 1'h1;
      issue(bus_cycle_pkg::CYC_MEM_RD, 32'h00003030, 1'h1);
      abort_req = 1'h1;
      settle(3);
      check("abort_float", bus.cache_oe, 1'h0);
      abort_req = 1'h0;
      settle(12);
      check("abort_done", req_ready, 1'h1);
   endtask
   // Reader stalls: two words fill the store, then drain
   task automatic t_buffer;
      rd_ready = 1'h0;
      sys_rd = 32'h11110001;
      issue(bus_cycle_pkg::CYC_MEM_RD, 32'h00002000, 1'h0);
      settle(6);
      sys_rd = 32'h22220002;
      issue(bus_cycle_pkg::CYC_MEM_RD, 32'h00002004, 1'h0);
      settle(6);
      check("full", req_ready, 1'h0);
      check("cache_nc", last_cache_n, 1'h1);
      check("head", cpu_rd, 32'h11110001);
      rd_ready = 1'h1;
      settle(1);
      check("second", cpu_rd, 32'h22220002);
      settle(1);
      check("empty", rd_valid, 1'h0);
   endtask
   task automatic t_burst;
      int s0, b0;
      for (int u = 1; u >= 0; u--) begin
         use_burst = u[0];
         s0 = strobes;
         b0 = beats;
         issue(bus_cycle_pkg::CYC_BURST_WB, 32'h00004008, 1'h1);
         settle(24);
         if (u == 1) check("burst_cache", last_cache_n, 1'h0);
         check("burst_beats", beats - b0, 4);
         check("burst_strobes", strobes - s0, u == 1 ? 1 : 4);
         check("burst_addr", last_addr, u == 1 ? 32'h00004000 : 32'h0000400C);
      end
      use_burst = 1'h1;
   endtask
   task automatic t_lock;
      int s0, b0, i0;
      s0 = strobes;
      i0 = invals;
      hit = 1'h1;
      issue(bus_cycle_pkg::CYC_LOCK_RD, 32'h00005000, 1'h1);
      hold_in = 1'h1;
      settle(10);
      check("lock_strobe", strobes - s0, 1);
      check("lock_inval", invals - i0, 1);
      check("lock_hold", bus.hold_grant_ack, 1'h0);
      hit = 1'h0;
      lock_last = 1'h1;
      issue(bus_cycle_pkg::CYC_LOCK_WR, 32'h00005000, 1'h0);
      settle(10);
      hold_in = 1'h0;
      lock_last = 1'h0;
      hit = 1'h1;
      dirty = 1'h1;
      settle(4);
      s0 = strobes;
      b0 = beats;
      issue(bus_cycle_pkg::CYC_LOCK_RD, 32'h00006004, 1'h1);
      settle(24);
      check("dirty_strobes", strobes - s0, 2);
      check("dirty_wb", beats - b0, 4);
      check("dirty_last", last_addr, 32'h00006004);
      hit = 1'h0;
      dirty = 1'h0;
      lock_last = 1'h1;
      issue(bus_cycle_pkg::CYC_LOCK_WR, 32'h00006004, 1'h0);
      settle(10);
      lock_last = 1'h0;
   endtask
   task automatic t_stop;
      int s0, r0;
      hold_in = 1'h1;
      settle(4);
      stop_want = 1'h1;
      settle(30);
      check("stop_in_hold", clock_stopped, 1'h0);
      hold_in = 1'h0;
      wait_stopped(1'h1);
      check("stopped", clock_stopped, 1'h1);
      check("grant_addr", last_addr, `STOP_GRANT_ADDR);
      check("granted", stop_granted, 1'h1);
      s0 = strobes;
      r0 = resumes;
      stop_want = 1'h0;
      wait_stopped(1'h0);
      settle(4);
      check("resume", resumes - r0, 1);
      check("no_ack", strobes - s0, 0);
      stop_want = 1'h1;
      wait_stopped(1'h1);
      check("restop", clock_stopped, 1'h1);
      stop_want = 1'h0;
      wait_stopped(1'h0);
   endtask
   task automatic t_priority;
      logic [5:0] rq [7] = '{6'h06, 6'h05, 6'h3E, 6'h38, 6'h30, 6'h20, 6'h00};
      logic [2:0] wb [7] = '{3'h1, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
      logic [2:0] wt [7] = '{3'h2, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
      for (int i = 0; i < 14; i++) begin
         wb_mode = i < 7;
         ext_req = rq[i % 7];
         #2 check("grant", ext_grant, wb_mode ? wb[i % 7] : wt[i % 7]);
         settle(1);
      end
   endtask
   initial begin
      settle(10);
      nrst = 1'h1;
      t_cache();
      t_buffer();
      t_burst();
      t_lock();
      t_stop();
      t_priority();
      finish_test();
   end
endmodule
